// >>> hw/pmoecr_consts.vh
// Constants for the output enable and system configuration register bank
`ifndef PMOECR_CONSTS_VH
`define PMOECR_CONSTS_VH

// ********************************************************************
// Register map
// ********************************************************************
`define PMOECR_ADDR_PASSWORD 8'h10
`define PMOECR_ADDR_OUT_EN 8'h12
`define PMOECR_ADDR_SYS_CFG 8'h13
`define PMOECR_RST_OUT_EN 8'h00
`define PMOECR_RST_SYS_CFG 8'h08
`define PMOECR_READ_ZERO 8'h00
// Unlock key: password write must equal target subaddress XOR this value (arbitrary)
`define PMOECR_UNLOCK_KEY 8'h5a

// ********************************************************************
// Output enable register fields
// ********************************************************************
`define PMOECR_OE_RESERVED 7
`define PMOECR_OE_THIRD_PIN 6
`define PMOECR_OE_SECOND_OUT 5
`define PMOECR_OE_FIRST_OUT 4
`define PMOECR_OE_SW_THREE 3
`define PMOECR_OE_SW_TWO 2
`define PMOECR_OE_SW_ONE 1
`define PMOECR_OE_LINEAR 0
`define PMOECR_OE_WRITE_MASK 8'h7f

// ********************************************************************
// System configuration register fields
// ********************************************************************
`define PMOECR_CF_PB_TIME 7
`define PMOECR_CF_BUF_TYPE 6
`define PMOECR_CF_ROUTING 5
`define PMOECR_CF_PG_DLY_HI 4
`define PMOECR_CF_PG_DLY_LO 3
`define PMOECR_CF_SUPERVISOR_STRICTNESS 2
`define PMOECR_CF_UNDERVOLTAGE_LOCKOUT_THRESHOLD_HI 1
`define PMOECR_CF_UNDERVOLTAGE_LOCKOUT_THRESHOLD_LO 0

// ********************************************************************
// Timing
// ********************************************************************
`define PMOECR_CLK_HZ 100000000
`define PMOECR_CYC_PER_MS (`PMOECR_CLK_HZ / 1000)
`define PMOECR_PG_DLY0_MS 10
`define PMOECR_PG_DLY1_MS 20
`define PMOECR_PG_DLY2_MS 50
`define PMOECR_PG_DLY3_MS 150
`define PMOECR_PB_SHORT_S 8
`define PMOECR_PB_LONG_S 15
`define PMOECR_PG_DLY0_CYC (`PMOECR_PG_DLY0_MS * `PMOECR_CYC_PER_MS)
`define PMOECR_PG_DLY1_CYC (`PMOECR_PG_DLY1_MS * `PMOECR_CYC_PER_MS)
`define PMOECR_PG_DLY2_CYC (`PMOECR_PG_DLY2_MS * `PMOECR_CYC_PER_MS)
`define PMOECR_PG_DLY3_CYC (`PMOECR_PG_DLY3_MS * `PMOECR_CYC_PER_MS)
`define PMOECR_PB_SHORT_CYC (`PMOECR_PB_SHORT_S * `PMOECR_CLK_HZ)
`define PMOECR_PB_LONG_CYC (`PMOECR_PB_LONG_S * `PMOECR_CLK_HZ)

`endif

// >>> hw/pmoecr_rise_delay.v
// Rising-edge qualification timer: output rises after a held-high time, falls at once
`default_nettype none

module pmoecr_rise_delay
(
    input wire clk_i,
    input wire reset_n_i,
    input wire level_i,
    input wire [31:0] count_i,
    output reg level_o
);

    reg [31:0] cnt;

    // ********************************************************************
    // Counter
    // ********************************************************************
    // A count of zero is treated as one so the output never skips the qualification
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt <= 32'h00000000;
            level_o <= 1'b0;
        end
        else if (!level_i)
        begin
            cnt <= 32'h00000000;
            level_o <= 1'b0;
        end
        else if (!level_o)
        begin
            if ((cnt + 32'h00000001) >= count_i)
                level_o <= 1'b1;
            else
                cnt <= cnt + 32'h00000001;
        end
    end

endmodule // pmoecr_rise_delay

`default_nettype wire

// >>> hw/pmoecr_regs.v
// Output enable and system configuration register bank with pin and timer logic
//
// Contract
// - Output enable register at 0x12, resets to 0x00, protected, bit 7 reads zero.
// - Bit 6 drives third pin low or releases it; ignored under warm-reset selection.
// - Bit 5 drives second output low, or releases it (open-drain) or drives it high (push-pull); ignored when first pin is input.
// - Bit 4 drives first output low or releases it; ignored when first pin is input.
// - Bits 3..0 enable switch three, two, one and the linear regulator.
// - Power sequencer updates switch one and regulator enables, overriding software.
// - Configuration register at 0x13, protected, resets to 0x08.
// - Configuration bit 7 picks push-button reset hold time, 8 s or 15 s.
// - Configuration bit 6 picks second output buffer: open-drain or push-pull.
// - Configuration bit 5 makes first pin an output, or an input steering second output.
// - Bits 4..3 pick power-good delay 10/20/50/150 ms, rising edges only.
// - Bit 2 picks tight limits with overvoltage monitoring, or wide without it.
// - Warm-reset selection turns third pin into a warm-reset input for two bucks.
`include "pmoecr_consts.vh"
`default_nettype none

module pmoecr_regs
#(
    parameter [31:0] PG_DLY0_CYC = `PMOECR_PG_DLY0_CYC,
    parameter [31:0] PG_DLY1_CYC = `PMOECR_PG_DLY1_CYC,
    parameter [31:0] PG_DLY2_CYC = `PMOECR_PG_DLY2_CYC,
    parameter [31:0] PG_DLY3_CYC = `PMOECR_PG_DLY3_CYC,
    parameter [31:0] PB_SHORT_CYC = `PMOECR_PB_SHORT_CYC,
    parameter [31:0] PB_LONG_CYC = `PMOECR_PB_LONG_CYC
)
(
    input wire CORE_CLK_I,
    input wire RESET_N_I,
    // Register port (subaddress, already decoded from the serial interface)
    input wire REG_WR_I,
    input wire REG_RD_I,
    input wire [7:0] REG_ADDR_I,
    input wire [7:0] REG_WDATA_I,
    output reg [7:0] REG_RDATA_O,
    output reg REG_RVALID_O,
    output reg UNLOCKED_O,
    // Power sequencer
    input wire SEQ_UPDATE_I,
    input wire SEQ_SWITCH_ONE_I,
    input wire SEQ_LINEAR_REG_I,
    // Selection held in the neighbouring configuration register
    input wire WARM_RESET_PIN_SELECT_I,
    // Analog status
    input wire PG_RAW_I,
    input wire PUSH_BUTTON_N_I,
    // Enables
    output reg SWITCH_THREE_ENABLE_O,
    output reg SWITCH_TWO_ENABLE_O,
    output reg SWITCH_ONE_ENABLE_O,
    output reg LINEAR_REG_ENABLE_O,
    // Third general pin, open-drain, also warm-reset input
    input wire THIRD_GENERAL_PIN_I,
    output reg THIRD_GENERAL_PIN_O,
    output reg THIRD_GENERAL_PIN_OE_N_O,
    output reg WARM_RESET_REQ_O,
    // First general pin, open-drain output or input
    input wire FIRST_GENERAL_PIN_I,
    output reg FIRST_GENERAL_PIN_O,
    output reg FIRST_GENERAL_PIN_OE_N_O,
    // Second general output, open-drain or push-pull
    output reg SECOND_GENERAL_OUTPUT_O,
    output reg SECOND_GENERAL_OUTPUT_OE_N_O,
    // Configuration decode
    output reg PB_RESET_O,
    output reg PG_O,
    output reg SUPERVISOR_STRICTNESS_O,
    output reg OV_MONITOR_EN_O,
    output reg [1:0] UNDERVOLTAGE_LOCKOUT_THRESHOLD_O
);

    // ********************************************************************
    // Address decode
    // ********************************************************************
    function is_protected;
        input [7:0] addr;
        begin
            is_protected = (addr == `PMOECR_ADDR_OUT_EN) || (addr == `PMOECR_ADDR_SYS_CFG);
        end
    endfunction

    // Open-drain pins: a set level bit or an overriding input role releases the pin
    function od_release;
        input level;
        input input_role;
        begin
            od_release = level | input_role;
        end
    endfunction

    // ********************************************************************
    // Second output buffer decode
    // ********************************************************************
    // Open-drain can only pull low, so a high level must release the pin rather than drive it
    function [1:0] second_drive;
        input level;
        input push_pull;
        begin
            second_drive = {level & push_pull, level & ~push_pull};
        end
    endfunction

    reg [7:0] out_en;
    reg [7:0] sys_cfg;
    reg [7:0] unlock_addr;
    reg unlocked;
    reg [7:0] next_out_en;
    reg [7:0] next_sys_cfg;
    reg [7:0] next_rdata;
    reg [31:0] pg_count;
    reg [31:0] pb_count;
    wire wr_pw;
    wire wr_ok;
    wire pg_delayed;
    wire pb_held;

    assign wr_pw = REG_WR_I && (REG_ADDR_I == `PMOECR_ADDR_PASSWORD);
    // Unlock is good for one write to the named subaddress only
    assign wr_ok = REG_WR_I && unlocked && is_protected(REG_ADDR_I) && (REG_ADDR_I == unlock_addr);

    // ********************************************************************
    // Password unlock
    // ********************************************************************
    // Any write other than the password consumes the unlock, so a stray write relocks
    always @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            unlocked <= 1'b0;
            unlock_addr <= 8'h00;
        end
        else if (wr_pw)
        begin
            unlock_addr <= REG_WDATA_I ^ `PMOECR_UNLOCK_KEY;
            unlocked <= is_protected(REG_WDATA_I ^ `PMOECR_UNLOCK_KEY);
        end
        else if (REG_WR_I)
        begin
            unlocked <= 1'b0;
        end
    end

    // ********************************************************************
    // Register update
    // ********************************************************************
    always @*
    begin
        next_out_en = out_en;
        next_sys_cfg = sys_cfg;
        if (wr_ok && (REG_ADDR_I == `PMOECR_ADDR_OUT_EN))
            next_out_en = REG_WDATA_I & `PMOECR_OE_WRITE_MASK;
        if (wr_ok && (REG_ADDR_I == `PMOECR_ADDR_SYS_CFG))
            next_sys_cfg = REG_WDATA_I;
        // Sequencer applied last so it wins over a software write in the same cycle
        if (SEQ_UPDATE_I)
        begin
            next_out_en[`PMOECR_OE_SW_ONE] = SEQ_SWITCH_ONE_I;
            next_out_en[`PMOECR_OE_LINEAR] = SEQ_LINEAR_REG_I;
        end
    end

    always @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            out_en <= `PMOECR_RST_OUT_EN;
            sys_cfg <= `PMOECR_RST_SYS_CFG;
        end
        else
        begin
            out_en <= next_out_en;
            sys_cfg <= next_sys_cfg;
        end
    end

    // ********************************************************************
    // Read port
    // ********************************************************************
    // Password and unmapped subaddresses read zero
    always @*
    begin
        case (REG_ADDR_I)
            `PMOECR_ADDR_OUT_EN: next_rdata = out_en & `PMOECR_OE_WRITE_MASK;
            `PMOECR_ADDR_SYS_CFG: next_rdata = sys_cfg;
            default: next_rdata = `PMOECR_READ_ZERO;
        endcase
    end

    always @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            REG_RDATA_O <= 8'h00;
            REG_RVALID_O <= 1'b0;
            UNLOCKED_O <= 1'b0;
        end
        else
        begin
            REG_RVALID_O <= REG_RD_I;
            UNLOCKED_O <= unlocked;
            if (REG_RD_I)
                REG_RDATA_O <= next_rdata;
        end
    end

    // ********************************************************************
    // Timers
    // ********************************************************************
    always @*
    begin
        case (sys_cfg[`PMOECR_CF_PG_DLY_HI:`PMOECR_CF_PG_DLY_LO])
            2'b00: pg_count = PG_DLY0_CYC;
            2'b01: pg_count = PG_DLY1_CYC;
            2'b10: pg_count = PG_DLY2_CYC;
            default: pg_count = PG_DLY3_CYC;
        endcase
        pb_count = sys_cfg[`PMOECR_CF_PB_TIME] ? PB_LONG_CYC : PB_SHORT_CYC;
    end

    // Falling power-good passes straight through, only the rise is held back
    pmoecr_rise_delay u_pg_delay
    (
        .clk_i(CORE_CLK_I),
        .reset_n_i(RESET_N_I),
        .level_i(PG_RAW_I),
        .count_i(pg_count),
        .level_o(pg_delayed)
    );

    pmoecr_rise_delay u_pb_delay
    (
        .clk_i(CORE_CLK_I),
        .reset_n_i(RESET_N_I),
        .level_i(~PUSH_BUTTON_N_I),
        .count_i(pb_count),
        .level_o(pb_held)
    );

    // ********************************************************************
    // Outputs
    // ********************************************************************
    always @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            SWITCH_THREE_ENABLE_O <= 1'b0;
            SWITCH_TWO_ENABLE_O <= 1'b0;
            SWITCH_ONE_ENABLE_O <= 1'b0;
            LINEAR_REG_ENABLE_O <= 1'b0;
            THIRD_GENERAL_PIN_O <= 1'b0;
            THIRD_GENERAL_PIN_OE_N_O <= 1'b0;
            WARM_RESET_REQ_O <= 1'b0;
            FIRST_GENERAL_PIN_O <= 1'b0;
            FIRST_GENERAL_PIN_OE_N_O <= 1'b0;
            SECOND_GENERAL_OUTPUT_O <= 1'b0;
            SECOND_GENERAL_OUTPUT_OE_N_O <= 1'b0;
            PB_RESET_O <= 1'b0;
            PG_O <= 1'b0;
            SUPERVISOR_STRICTNESS_O <= 1'b0;
            OV_MONITOR_EN_O <= 1'b0;
            UNDERVOLTAGE_LOCKOUT_THRESHOLD_O <= 2'b00;
        end
        else
        begin
            SWITCH_THREE_ENABLE_O <= out_en[`PMOECR_OE_SW_THREE];
            SWITCH_TWO_ENABLE_O <= out_en[`PMOECR_OE_SW_TWO];
            SWITCH_ONE_ENABLE_O <= out_en[`PMOECR_OE_SW_ONE];
            LINEAR_REG_ENABLE_O <= out_en[`PMOECR_OE_LINEAR];

            // Third pin: level bit drives low or releases; warm-reset input when selected
            THIRD_GENERAL_PIN_O <= 1'b0;
            THIRD_GENERAL_PIN_OE_N_O <=
                od_release(out_en[`PMOECR_OE_THIRD_PIN], WARM_RESET_PIN_SELECT_I);
            WARM_RESET_REQ_O <= WARM_RESET_PIN_SELECT_I & ~THIRD_GENERAL_PIN_I;

            // First pin: open-drain output, or released to act as input
            FIRST_GENERAL_PIN_O <= 1'b0;
            FIRST_GENERAL_PIN_OE_N_O <=
                od_release(out_en[`PMOECR_OE_FIRST_OUT], sys_cfg[`PMOECR_CF_ROUTING]);

            // Second output: level from its bit or from the first pin input
            if (sys_cfg[`PMOECR_CF_ROUTING])
            begin
                {SECOND_GENERAL_OUTPUT_O, SECOND_GENERAL_OUTPUT_OE_N_O} <=
                    second_drive(FIRST_GENERAL_PIN_I, sys_cfg[`PMOECR_CF_BUF_TYPE]);
            end
            else
            begin
                {SECOND_GENERAL_OUTPUT_O, SECOND_GENERAL_OUTPUT_OE_N_O} <=
                    second_drive(out_en[`PMOECR_OE_SECOND_OUT], sys_cfg[`PMOECR_CF_BUF_TYPE]);
            end

            PB_RESET_O <= pb_held;
            PG_O <= pg_delayed;
            SUPERVISOR_STRICTNESS_O <= sys_cfg[`PMOECR_CF_SUPERVISOR_STRICTNESS];
            OV_MONITOR_EN_O <= sys_cfg[`PMOECR_CF_SUPERVISOR_STRICTNESS];
            UNDERVOLTAGE_LOCKOUT_THRESHOLD_O <= sys_cfg[`PMOECR_CF_UNDERVOLTAGE_LOCKOUT_THRESHOLD_HI:`PMOECR_CF_UNDERVOLTAGE_LOCKOUT_THRESHOLD_LO];
        end
    end

endmodule // pmoecr_regs

`default_nettype wire

// >>> verif/pmoecr_regs_properties.sv
// Concurrent checks on the register bank ports
`default_nettype none
module pmoecr_regs_chk
(
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic REG_RVALID_O,
    input wire logic SEQ_UPDATE_I,
    input wire logic SEQ_SWITCH_ONE_I,
    input wire logic SEQ_LINEAR_REG_I,
    input wire logic PG_RAW_I,
    input wire logic PG_O,
    input wire logic SWITCH_THREE_ENABLE_O,
    input wire logic SWITCH_TWO_ENABLE_O,
    input wire logic SWITCH_ONE_ENABLE_O,
    input wire logic LINEAR_REG_ENABLE_O,
    input wire logic FIRST_GENERAL_PIN_O,
    input wire logic THIRD_GENERAL_PIN_O,
    input wire logic SECOND_GENERAL_OUTPUT_O,
    input wire logic SECOND_GENERAL_OUTPUT_OE_N_O,
    input wire logic SUPERVISOR_STRICTNESS_O,
    input wire logic OV_MONITOR_EN_O,
    input wire logic [1:0] UNDERVOLTAGE_LOCKOUT_THRESHOLD_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Unlock tracking and power-good high time
    // ****************************************
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    logic ok12;
    logic ok13;
    logic [7:0] hi_cnt;
    wire logic w12 = REG_WR_I && (REG_ADDR_I == 8'h12);
    wire logic w13 = REG_WR_I && (REG_ADDR_I == 8'h13);
    // Any write re-arms or clears the one-shot unlock
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            ok12 <= 1'b0;
            ok13 <= 1'b0;
            hi_cnt <= 8'h00;
        end
        else
        begin
            if (REG_WR_I)
            begin
                ok12 <= (REG_ADDR_I == 8'h10) && (REG_WDATA_I == 8'h48);
                ok13 <= (REG_ADDR_I == 8'h10) && (REG_WDATA_I == 8'h49);
            end
            hi_cnt <= !PG_RAW_I ? 8'h00 : ((hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01);
        end
    end
    wr_refused_a: assert property (w12 && !ok12 |->
        ##2 $stable(SWITCH_THREE_ENABLE_O) && $stable(SWITCH_TWO_ENABLE_O)) else $error("locked write took effect");
    wr_taken_a: assert property (w12 && ok12 && !SEQ_UPDATE_I |-> ##2
        {SWITCH_THREE_ENABLE_O, SWITCH_TWO_ENABLE_O, SWITCH_ONE_ENABLE_O, LINEAR_REG_ENABLE_O}
        == $past(REG_WDATA_I[3:0], 2)) else $error("enable outputs do not follow write");
    cfg_taken_a: assert property (w13 && ok13 |-> ##2
        {SUPERVISOR_STRICTNESS_O, UNDERVOLTAGE_LOCKOUT_THRESHOLD_O} == $past(REG_WDATA_I[2:0], 2))
        else $error("config decode does not follow write");
    cfg_refused_a: assert property (w13 && !ok13 |-> ##2 $stable(UNDERVOLTAGE_LOCKOUT_THRESHOLD_O))
        else $error("locked config write took effect");
    seq_load_a: assert property (SEQ_UPDATE_I |-> ##2 SWITCH_ONE_ENABLE_O == $past(SEQ_SWITCH_ONE_I, 2)
        && LINEAR_REG_ENABLE_O == $past(SEQ_LINEAR_REG_I, 2)) else $error("sequencer load missed");
    rsvd_zero_a: assert property (REG_RD_I && REG_ADDR_I == 8'h12 |=> REG_RVALID_O && !REG_RDATA_O[7])
        else $error("reserved bit read as one");
    supervisor_strictness_pair_a: assert property (SUPERVISOR_STRICTNESS_O == OV_MONITOR_EN_O)
        else $error("overvoltage enable differs from strictness");
    pg_fall_a: assert property ($fell(PG_RAW_I) |-> ##[1:3] !PG_O)
        else $error("power good fall delayed");
    pg_rise_a: assert property ($rose(PG_O) |-> hi_cnt >= 8'h0a)
        else $error("power good rose too early");
    drive_low_a: assert property (!FIRST_GENERAL_PIN_O && !THIRD_GENERAL_PIN_O)
        else $error("open-drain pin driven high");
    pp_level_a: assert property (SECOND_GENERAL_OUTPUT_O |-> !SECOND_GENERAL_OUTPUT_OE_N_O)
        else $error("second output high while not driven");
    cover property (w12 && ok12);
    cover property (w13 && !ok13);
    cover property ($rose(PG_O));
endmodule // pmoecr_regs_chk
bind pmoecr_regs pmoecr_regs_chk i_chk (.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
    .REG_RVALID_O(REG_RVALID_O), .SEQ_UPDATE_I(SEQ_UPDATE_I), .SEQ_SWITCH_ONE_I(SEQ_SWITCH_ONE_I),
    .SEQ_LINEAR_REG_I(SEQ_LINEAR_REG_I), .PG_RAW_I(PG_RAW_I), .PG_O(PG_O),
    .SWITCH_THREE_ENABLE_O(SWITCH_THREE_ENABLE_O), .SWITCH_TWO_ENABLE_O(SWITCH_TWO_ENABLE_O),
    .SWITCH_ONE_ENABLE_O(SWITCH_ONE_ENABLE_O), .LINEAR_REG_ENABLE_O(LINEAR_REG_ENABLE_O),
    .FIRST_GENERAL_PIN_O(FIRST_GENERAL_PIN_O), .THIRD_GENERAL_PIN_O(THIRD_GENERAL_PIN_O),
    .SECOND_GENERAL_OUTPUT_O(SECOND_GENERAL_OUTPUT_O), .SECOND_GENERAL_OUTPUT_OE_N_O(SECOND_GENERAL_OUTPUT_OE_N_O),
    .SUPERVISOR_STRICTNESS_O(SUPERVISOR_STRICTNESS_O), .OV_MONITOR_EN_O(OV_MONITOR_EN_O),
    .UNDERVOLTAGE_LOCKOUT_THRESHOLD_O(UNDERVOLTAGE_LOCKOUT_THRESHOLD_O));
`default_nettype wire

// >>> verif/pmic_output_enable_config_regs_tb_top.sv
// Self-checking bench for the output enable and configuration register bank
`include "pmoecr_consts.vh"
`default_nettype none
module pmic_output_enable_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, seq_up = 1'b0, seq_one = 1'b0, seq_lin = 1'b0;
    logic warm_sel = 1'b0, pg_raw = 1'b0, pb_n = 1'b1, pin3_in = 1'b1, pin1_in = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    wire [7:0] rdata;
    wire [1:0] undervoltage_lockout_threshold;
    wire rvalid, unl, en3, en2, en1, enl, p3o, p3oe, wrq, p1o, p1oe, g2o, g2oe, pbr, pg, supervisor_strictness, ovm;
    int fail_count = 0, checks = 0, cyc = 0;
    // ****************************************
    // Device and helpers
    // ****************************************
    // Short counts keep every timer scenario within a few hundred cycles
    pmoecr_regs #(.PG_DLY0_CYC(32'ha), .PG_DLY1_CYC(32'h14), .PG_DLY2_CYC(32'h32), .PG_DLY3_CYC(32'h96),
        .PB_SHORT_CYC(32'h50), .PB_LONG_CYC(32'h96)) i_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
        .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .REG_RVALID_O(rvalid), .UNLOCKED_O(unl), .SEQ_UPDATE_I(seq_up), .SEQ_SWITCH_ONE_I(seq_one),
        .SEQ_LINEAR_REG_I(seq_lin), .WARM_RESET_PIN_SELECT_I(warm_sel), .PG_RAW_I(pg_raw), .PUSH_BUTTON_N_I(pb_n),
        .SWITCH_THREE_ENABLE_O(en3), .SWITCH_TWO_ENABLE_O(en2), .SWITCH_ONE_ENABLE_O(en1),
        .LINEAR_REG_ENABLE_O(enl), .THIRD_GENERAL_PIN_I(pin3_in), .THIRD_GENERAL_PIN_O(p3o),
        .THIRD_GENERAL_PIN_OE_N_O(p3oe), .WARM_RESET_REQ_O(wrq), .FIRST_GENERAL_PIN_I(pin1_in),
        .FIRST_GENERAL_PIN_O(p1o), .FIRST_GENERAL_PIN_OE_N_O(p1oe), .SECOND_GENERAL_OUTPUT_O(g2o),
        .SECOND_GENERAL_OUTPUT_OE_N_O(g2oe), .PB_RESET_O(pbr), .PG_O(pg), .SUPERVISOR_STRICTNESS_O(supervisor_strictness),
        .OV_MONITOR_EN_O(ovm), .UNDERVOLTAGE_LOCKOUT_THRESHOLD_O(undervoltage_lockout_threshold));
    task close_out();
        $display("Comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_s = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr_s = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task pwr(input logic [7:0] a, input logic [7:0] d);
        wr(8'h10, a ^ `PMOECR_UNLOCK_KEY);
        wr(a, d);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd_s = 1'b1;
        addr = a;
        @(negedge clk);
        rd_s = 1'b0;
        chk(rvalid, 8'h01);
        chk(rdata, exp);
    endtask
    task meas(input logic sel, input int n);
        int c;
        c = 0;
        while (((sel ? pbr : pg) !== 1'b1) && c < 400)
        begin
            @(negedge clk);
            c++;
        end
        chk(c >= n && c <= n + 4, 8'h01);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset();
        rd(8'h12, 8'h00);
        rd(8'h13, 8'h08);
        rd(8'h21, 8'h00);
        chk({en3, en2, en1, enl}, 8'h00);
    endtask
    task t_lock();
        wr(8'h12, 8'hff);
        rd(8'h12, 8'h00);
        wr(8'h10, 8'h49);
        chk(unl, 8'h01);
        wr(8'h12, 8'hff);
        chk(unl, 8'h00);
        rd(8'h12, 8'h00);
        pwr(8'h12, 8'hff);
        rd(8'h12, 8'h7f);
        chk({en3, en2, en1, enl}, 8'h0f);
        wr(8'h12, 8'h00);
        rd(8'h12, 8'h7f);
        pwr(8'h12, 8'h05);
        chk({en3, en2, en1, enl}, 8'h05);
    endtask
    task t_cfg();
        for (int i = 0; i < 8; i++)
        begin
            pwr(8'h13, 8'h08 | i[7:0]);
            chk(undervoltage_lockout_threshold, i[1:0]);
            chk(supervisor_strictness, i[2]);
            chk(ovm, i[2]);
            rd(8'h13, 8'h08 | i[7:0]);
        end
    endtask
    task t_pins();
        pwr(8'h13, 8'h08);
        pwr(8'h12, 8'h00);
        chk({p1oe, p3oe, g2oe}, 8'h00);
        chk({p1o, p3o}, 8'h00);
        pwr(8'h12, 8'h70);
        chk({p1oe, p3oe, g2oe, g2o}, 8'h0e);
        pwr(8'h13, 8'h48);
        chk({g2oe, g2o}, 8'h01);
        pwr(8'h12, 8'h00);
        chk({g2oe, g2o}, 8'h00);
        pwr(8'h13, 8'h28);
        pin1_in = 1'b0;
        repeat (3) @(negedge clk);
        chk({p1oe, g2oe}, 8'h02);
        pin1_in = 1'b1;
        repeat (3) @(negedge clk);
        chk({p1oe, g2oe}, 8'h03);
        pwr(8'h13, 8'h08);
        warm_sel = 1'b1;
        pin3_in = 1'b0;
        repeat (3) @(negedge clk);
        chk({p3oe, wrq}, 8'h03);
        pin3_in = 1'b1;
        repeat (3) @(negedge clk);
        chk(wrq, 8'h00);
        warm_sel = 1'b0;
        repeat (3) @(negedge clk);
        chk(p3oe, 8'h00);
    endtask
    task t_seq();
        pwr(8'h12, 8'h02);
        @(negedge clk);
        seq_up = 1'b1;
        seq_lin = 1'b1;
        @(negedge clk);
        seq_up = 1'b0;
        repeat (3) @(negedge clk);
        chk({en1, enl}, 8'h01);
        rd(8'h12, 8'h01);
        @(negedge clk);
        seq_up = 1'b1;
        seq_one = 1'b1;
        seq_lin = 1'b0;
        @(negedge clk);
        seq_up = 1'b0;
        repeat (3) @(negedge clk);
        chk({en1, enl}, 8'h02);
        rd(8'h12, 8'h02);
    endtask
    task t_timers();
        int n [4] = '{10, 20, 50, 150};
        for (int k = 0; k < 4; k++)
        begin
            pwr(8'h13, {3'h0, k[1:0], 3'h0});
            pg_raw = 1'b1;
            meas(1'b0, n[k]);
            pg_raw = 1'b0;
            repeat (3) @(negedge clk);
            chk(pg, 8'h00);
        end
        for (int b = 0; b < 2; b++)
        begin
            pwr(8'h13, {b[0], 7'h08});
            pb_n = 1'b0;
            meas(1'b1, b ? 150 : 80);
            pb_n = 1'b1;
            repeat (3) @(negedge clk);
            chk(pbr, 8'h00);
        end
    endtask
    initial
    begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            close_out();
        end
    end
    initial
    begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_lock();
        t_cfg();
        t_pins();
        t_seq();
        t_timers();
        close_out();
    end
endmodule // pmic_output_enable_config_regs_tb_top
`default_nettype wire
